// ==== rtl/irda_secondary_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module sync_fifo #(
  parameter int W     = irda_port_pkg::DATA_W,
  parameter int DEPTH = irda_port_pkg::FIFO_DEPTH
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic [W-1:0]             in_data,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  output logic [W-1:0]                  out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;

  // depth must be a power of two; pointers carry one wrap bit
  assign level     = wp - rp;
  assign in_ready  = level != (AW + 1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem[rp[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && in_ready) begin
        mem[wp[AW-1:0]] <= in_data;
        wp <= wp + 1'b1;
      end
      if (out_valid && out_ready) rp <= rp + 1'b1;
    end
  end
endmodule

module irda_secondary_port #(
  parameter int BIT_CYC = irda_port_pkg::BIT_CYCLES,
  parameter int DEPTH   = irda_port_pkg::FIFO_DEPTH
) (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  host_uart_if.dev_end port,
  output logic        infrared_tx_out,
  input  wire logic   infrared_rx_in,
  output logic        link_up
);
  localparam int DW = irda_port_pkg::DATA_W;
  localparam int FW = irda_port_pkg::FRAME_W;
  localparam int LW = $clog2(DEPTH) + 1;

  // true for a control frame carrying the given code
  function automatic logic ctrl_is(input logic [FW-1:0] f, input logic [DW-1:0] code);
    return f[irda_port_pkg::FRAME_CTRL] && f[DW-1:0] == code;
  endfunction

  logic [2:0]    ir_sync;
  logic          ir_line;
  logic [DW-1:0] host_rx_data;
  logic          host_rx_valid;
  logic [DW-1:0] up_data;
  logic          up_valid;
  logic          up_ready;
  logic [LW-1:0] up_level;
  logic [FW-1:0] ir_rx_data;
  logic          ir_rx_valid;
  logic          down_in_valid;
  logic [DW-1:0] down_data;
  logic          down_valid;
  logic          down_ready;
  logic          host_tx_ready;
  logic          host_tx_go;
  logic [FW-1:0] ir_frame;
  logic          ir_go;
  logic          ir_ready;
  logic          linked;
  logic          force_status;
  logic [irda_port_pkg::STAT_W-1:0] cur_status;
  logic [irda_port_pkg::STAT_W-1:0] sent_status;
  logic          need_status;
  logic          is_ctrl;

  // infrared receive pin: three stages, accepted once the last two agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ir_sync <= 3'h7;
      ir_line <= 1'b1;
    end else begin
      ir_sync <= {ir_sync[1:0], infrared_rx_in};
      if (ir_sync[1] == ir_sync[2]) ir_line <= ir_sync[2];
    end
  end

  // host to link path: chars from the host queue until a link drains them
  ser_rx #(.W(DW), .BIT_CYC(BIT_CYC)) u_host_rx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .line    (port.ser_to_dev),
    .data    (host_rx_data),
    .valid   (host_rx_valid)
  );

  sync_fifo #(.W(DW), .DEPTH(DEPTH)) u_up_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (host_rx_data),
    .in_valid  (host_rx_valid),
    .in_ready  (),
    .out_data  (up_data),
    .out_valid (up_valid),
    .out_ready (up_ready),
    .level     (up_level)
  );

  // clear-to-send from local buffer room, leaving space for a char in flight
  always_ff @(posedge clk_sys) begin
    if (rst) port.cts_n <= 1'b1;
    else port.cts_n <= up_level >= LW'(DEPTH - irda_port_pkg::CTS_SLACK);
  end

  // modem lines seen by the primary, asserted-high; ring, carrier and host DTR
  assign cur_status[irda_port_pkg::STAT_RI]  = !port.ring_n;
  assign cur_status[irda_port_pkg::STAT_CD]  = !port.cd_n;
  assign cur_status[irda_port_pkg::STAT_DSR] = !port.dtr_n;
  assign need_status = linked && (force_status || cur_status != sent_status);

  // link transmit arbiter: status first, then data; silent while unlinked
  always_comb begin
    ir_go    = 1'b0;
    up_ready = 1'b0;
    ir_frame = {1'b0, up_data};
    if (ir_ready && need_status) begin
      ir_go    = 1'b1;
      ir_frame = {1'b1, irda_port_pkg::CTRL_STATUS | DW'(cur_status)};
    end else if (ir_ready && linked && up_valid) begin
      ir_go    = 1'b1;
      up_ready = 1'b1;
    end
  end

  ser_tx #(.W(FW), .BIT_CYC(BIT_CYC)) u_ir_tx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .data    (ir_frame),
    .valid   (ir_go),
    .ready   (ir_ready),
    .line    (infrared_tx_out)
  );

  ser_rx #(.W(FW), .BIT_CYC(BIT_CYC)) u_ir_rx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .line    (ir_line),
    .data    (ir_rx_data),
    .valid   (ir_rx_valid)
  );

  assign is_ctrl = ir_rx_data[irda_port_pkg::FRAME_CTRL];

  // link state follows the primary only; remote status frames are ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      linked <= 1'b0;
    end else if (ir_rx_valid && is_ctrl) begin
      if (ctrl_is(ir_rx_data, irda_port_pkg::CTRL_CONNECT)) linked <= 1'b1;
      else if (ctrl_is(ir_rx_data, irda_port_pkg::CTRL_DISCONNECT)) linked <= 1'b0;
    end
  end

  // status owed after connect; a new connect wins over a send in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      force_status <= 1'b0;
      sent_status  <= '0;
    end else begin
      if (ir_go && ir_frame[irda_port_pkg::FRAME_CTRL]) begin
        force_status <= 1'b0;
        sent_status  <= cur_status;
      end
      if (ir_rx_valid && ctrl_is(ir_rx_data, irda_port_pkg::CTRL_CONNECT)) force_status <= 1'b1;
    end
  end

  // DSR and link flag from link state alone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port.dsr_n <= 1'b1;
      link_up    <= 1'b0;
    end else begin
      port.dsr_n <= !linked;
      link_up    <= linked;
    end
  end

  // link to host path
  assign down_in_valid = ir_rx_valid && !is_ctrl && linked;

  sync_fifo #(.W(DW), .DEPTH(DEPTH)) u_down_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (ir_rx_data[DW-1:0]),
    .in_valid  (down_in_valid),
    .in_ready  (),
    .out_data  (down_data),
    .out_valid (down_valid),
    .out_ready (down_ready),
    .level     ()
  );

  // a char starts only while the host lowers RTS; a char under way finishes
  assign host_tx_go = down_valid && !port.rts_n && host_tx_ready;
  assign down_ready = host_tx_go;

  ser_tx #(.W(DW), .BIT_CYC(BIT_CYC)) u_host_tx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .data    (down_data),
    .valid   (host_tx_go),
    .ready   (host_tx_ready),
    .line    (port.ser_to_host)
  );
endmodule
`default_nettype wire

// ==== include/irda_port_pkg.sv ====
`default_nettype none
package irda_port_pkg;
  // system clock and host serial rate
  localparam int CLK_HZ     = 20_000_000;
  localparam int BAUD       = 115_200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  // character widths: host chars are bytes, link frames carry a control flag above the byte
  localparam int DATA_W     = 8;
  localparam int FRAME_W    = DATA_W + 1;
  localparam int FRAME_CTRL = DATA_W;
  localparam int FIFO_DEPTH = 8;
  // flow-control headroom: host is stopped while this few slots or fewer are free
  localparam int CTS_SLACK  = 2;
  // link control frame codes
  localparam logic [7:0] CTRL_CONNECT    = 8'h01;
  localparam logic [7:0] CTRL_DISCONNECT = 8'h02;
  localparam logic [7:0] CTRL_STATUS     = 8'h10;
  // status frame field positions, each bit high when the line is asserted
  localparam int STAT_RI  = 0;
  localparam int STAT_CD  = 1;
  localparam int STAT_DSR = 2;
  localparam int STAT_W   = 3;
endpackage
`default_nettype wire

// ==== include/host_uart_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface host_uart_if;
  logic ser_to_dev;
  logic ser_to_host;
  logic ring_n;
  logic cd_n;
  logic dtr_n;
  logic dsr_n;
  logic cts_n;
  logic rts_n;
  modport dev_end  (input ser_to_dev, ring_n, cd_n, dtr_n, rts_n, output ser_to_host, dsr_n, cts_n);
  modport host_end (output ser_to_dev, ring_n, cd_n, dtr_n, rts_n, input ser_to_host, dsr_n, cts_n);
endinterface
`default_nettype wire

// ==== rtl/host_uart_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// serialiser shared by both ends: start bit, W data bits lsb first, one stop bit
module ser_tx #(
  parameter int W       = irda_port_pkg::DATA_W,
  parameter int BIT_CYC = irda_port_pkg::BIT_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] data,
  input  wire logic         valid,
  output logic              ready,
  output logic              line
);
  logic [W:0]  sh;
  logic [4:0]  left;
  logic [15:0] cyc;
  logic        busy;

  assign ready = !busy;

  // line idles high; ready again only after the full stop period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy <= 1'b0;
      line <= 1'b1;
      sh   <= '0;
      left <= 5'h00;
      cyc  <= 16'h0000;
    end else if (!busy) begin
      if (valid) begin
        busy <= 1'b1;
        line <= 1'b0;
        sh   <= {1'b1, data};
        left <= 5'(W + 1);
        cyc  <= 16'h0000;
      end
    end else if (cyc == 16'(BIT_CYC - 1)) begin
      cyc <= 16'h0000;
      if (left == 5'h00) begin
        busy <= 1'b0;
      end else begin
        line <= sh[0];
        sh   <= {1'b1, sh[W:1]};
        left <= left - 5'h01;
      end
    end else begin
      cyc <= cyc + 16'h0001;
    end
  end
endmodule

module ser_rx #(
  parameter int W       = irda_port_pkg::DATA_W,
  parameter int BIT_CYC = irda_port_pkg::BIT_CYCLES
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         line,
  output logic [W-1:0]      data,
  output logic              valid
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  rx_state_t   state;
  logic [W-1:0] sh;
  logic [4:0]  n;
  logic [15:0] cyc;

  // samples each bit at its centre; a frame with a bad stop bit is discarded
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= RX_IDLE;
      sh    <= '0;
      data  <= '0;
      n     <= 5'h00;
      cyc   <= 16'h0000;
      valid <= 1'b0;
    end else begin
      valid <= 1'b0;
      cyc   <= cyc + 16'h0001;
      unique case (state)
        RX_IDLE: begin
          cyc <= 16'h0000;
          if (!line) state <= RX_START;
        end
        RX_START: begin
          if (cyc == 16'(BIT_CYC / 2 - 1)) begin
            cyc   <= 16'h0000;
            n     <= 5'h00;
            state <= line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (cyc == 16'(BIT_CYC - 1)) begin
            cyc <= 16'h0000;
            sh  <= {line, sh[W-1:1]};
            if (n == 5'(W - 1)) state <= RX_STOP;
            else n <= n + 5'h01;
          end
        end
        RX_STOP: begin
          if (cyc == 16'(BIT_CYC - 1)) begin
            valid <= line;
            data  <= sh;
            state <= RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

module host_uart_ctrl #(
  parameter int BIT_CYC = irda_port_pkg::BIT_CYCLES
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  host_uart_if.host_end                      port,
  input  wire logic [irda_port_pkg::DATA_W-1:0] tx_data,
  input  wire logic                          tx_valid,
  output logic                               tx_ready,
  output logic [irda_port_pkg::DATA_W-1:0]   rx_data,
  output logic                               rx_valid,
  input  wire logic                          ready_for_ir,
  input  wire logic                          rx_allow,
  input  wire logic                          ring,
  input  wire logic                          carrier,
  output logic                               link_up,
  output logic                               device_reset_n
);
  localparam int DW = irda_port_pkg::DATA_W;

  logic [DW-1:0] hold;
  logic          hold_full;
  logic          next_full;
  logic          ser_ready;
  logic          launch;

  // one-char holding stage; a char starts only while CTS is low
  assign launch    = hold_full && ser_ready && !port.cts_n;
  assign next_full = (hold_full && !launch) || (tx_valid && tx_ready);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_full <= 1'b0;
      hold      <= '0;
      tx_ready  <= 1'b0;
    end else begin
      hold_full <= next_full;
      tx_ready  <= !next_full;
      if (tx_valid && tx_ready) hold <= tx_data;
    end
  end

  ser_tx #(.W(DW), .BIT_CYC(BIT_CYC)) u_tx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .data    (hold),
    .valid   (launch),
    .ready   (ser_ready),
    .line    (port.ser_to_dev)
  );

  ser_rx #(.W(DW), .BIT_CYC(BIT_CYC)) u_rx (
    .clk_sys (clk_sys),
    .rst     (rst),
    .line    (port.ser_to_host),
    .data    (rx_data),
    .valid   (rx_valid)
  );

  // modem-control outputs, all active low on the wire
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port.dtr_n     <= 1'b1;
      port.rts_n     <= 1'b1;
      port.ring_n    <= 1'b1;
      port.cd_n      <= 1'b1;
      link_up        <= 1'b0;
      device_reset_n <= 1'b0;
    end else begin
      port.dtr_n     <= !ready_for_ir;
      port.rts_n     <= !rx_allow;
      port.ring_n    <= !ring;
      port.cd_n      <= !carrier;
      link_up        <= !port.dsr_n;
      device_reset_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== sim/irda_port_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module irda_port_checker #(
  parameter int BIT_CYC = irda_port_pkg::BIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ser_to_dev,
  input wire logic ser_to_host,
  input wire logic ring_n,
  input wire logic cd_n,
  input wire logic dtr_n,
  input wire logic dsr_n,
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic infrared_tx_out,
  input wire logic link_up,
  input wire logic ready_for_ir,
  input wire logic rx_allow,
  input wire logic ring,
  input wire logic carrier
);
  int h_cnt;
  int d_cnt;
  int l_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // cycles left in the frame now running on each serial line, so data bits are not taken for starts
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      h_cnt <= 0;
      d_cnt <= 0;
      l_cnt <= 0;
    end else begin
      h_cnt <= h_cnt > 0 ? h_cnt - 1 : ($fell(ser_to_dev) ? 10 * BIT_CYC - 2 : 0);
      d_cnt <= d_cnt > 0 ? d_cnt - 1 : ($fell(ser_to_host) ? 10 * BIT_CYC - 2 : 0);
      l_cnt <= l_cnt > 0 ? l_cnt - 1 : ($fell(infrared_tx_out) ? 11 * BIT_CYC - 2 : 0);
    end
  end
  // link state, flow control and modem lines at the port
  a_dsr_tracks_link: assert property (
    dsr_n != link_up) else $error("dsr_n disagrees with link state");
  a_link_start_linked: assert property (
    (l_cnt == 0 && $fell(infrared_tx_out)) |-> ##[0:3] link_up) else $error("link frame sent while unlinked");
  a_host_waits_cts: assert property (
    (h_cnt == 0 && $fell(ser_to_dev)) |-> !$past(cts_n)) else $error("host char started with cts_n high");
  a_dev_waits_rts: assert property (
    (d_cnt == 0 && $fell(ser_to_host)) |-> !$past(rts_n)) else $error("device char started with rts_n high");
  a_reset_idle_levels: assert property (
    $past(rst) |-> ser_to_host && ser_to_dev && dsr_n && cts_n && dtr_n && rts_n && infrared_tx_out && !link_up)
    else $error("lines not idle after reset");
  a_cts_open_after: assert property (
    $past(rst, 2) && !$past(rst) |-> !cts_n) else $error("cts_n not low with empty buffer");
  a_dtr_follows_ready: assert property (
    !$past(rst) |-> dtr_n == !$past(ready_for_ir)) else $error("dtr_n does not follow ready");
  a_host_line_levels: assert property (
    !$past(rst) |-> {ring_n, cd_n, rts_n} == ~{$past(ring), $past(carrier), $past(rx_allow)})
    else $error("modem line levels wrong");
endmodule
`default_nettype wire

// ==== sim/irda_stack_host_uart_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module irda_stack_host_uart_port_bench;
  localparam int BC = 16;
  localparam int FB = 11 * BC;
  logic       clk_sys = 1'h0;
  logic       rst = 1'h1;
  logic [7:0] tx_data = 8'h00;
  logic       tx_valid = 1'h0;
  logic       ready_for_ir = 1'h0;
  logic       rx_allow = 1'h0;
  logic       ring = 1'h0;
  logic       carrier = 1'h0;
  logic       ir_in = 1'h1;
  logic       ir_out;
  logic       tx_ready;
  logic       rx_valid;
  logic       dev_link;
  logic       host_link;
  logic       dev_rst_n;
  logic [7:0] rx_data;
  logic [8:0] lbits;
  logic [8:0] lq[$];
  logic [7:0] hq[$];
  logic [7:0] eq[$];
  logic [7:0] b;
  logic [2:0] ml;
  int         bad_count = 0;
  int         comparisons = 0;
  int         seed = 32'h53e2;

  // clock
  always #25 clk_sys = ~clk_sys;

  // both ends joined across the host serial interface
  host_uart_if port_if ();
  irda_secondary_port #(.BIT_CYC(BC)) i_irda_secondary_port (.clk_sys(clk_sys), .rst(rst),
    .port(port_if.dev_end), .infrared_tx_out(ir_out), .infrared_rx_in(ir_in), .link_up(dev_link));
  host_uart_ctrl #(.BIT_CYC(BC)) i_host_uart_ctrl (.clk_sys(clk_sys), .rst(rst), .port(port_if.host_end),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .ready_for_ir(ready_for_ir), .rx_allow(rx_allow), .ring(ring), .carrier(carrier), .link_up(host_link),
    .device_reset_n(dev_rst_n));
  irda_port_checker #(.BIT_CYC(BC)) i_irda_port_checker (.clk_sys(clk_sys), .rst(rst),
    .ser_to_dev(port_if.ser_to_dev), .ser_to_host(port_if.ser_to_host), .ring_n(port_if.ring_n),
    .cd_n(port_if.cd_n), .dtr_n(port_if.dtr_n), .dsr_n(port_if.dsr_n), .cts_n(port_if.cts_n),
    .rts_n(port_if.rts_n), .infrared_tx_out(ir_out), .link_up(dev_link), .ready_for_ir(ready_for_ir),
    .rx_allow(rx_allow), .ring(ring), .carrier(carrier));

  // decode frames the device sends toward the primary, sampling mid-bit
  initial begin
    forever begin
      @(negedge ir_out);
      repeat (BC / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++) begin
        repeat (BC) @(posedge clk_sys);
        lbits[i] = ir_out;
      end
      repeat (BC) @(posedge clk_sys);
      lq.push_back(lbits);
    end
  end

  // collect chars handed to the host user side
  always @(posedge clk_sys) if (rx_valid === 1'h1) hq.push_back(rx_data);

  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // wait a bounded time for the next link frame or host char, then compare
  task automatic take(input bit host, input logic [8:0] exp);
    int n;
    n = 0;
    while ((host ? hq.size() : lq.size()) == 0 && n < 4 * FB) begin
      @(posedge clk_sys);
      n++;
    end
    if (host) chk("host char", exp, hq.size() > 0 ? {1'h0, hq.pop_front()} : ~exp);
    else chk("link frame", exp, lq.size() > 0 ? lq.pop_front() : ~exp);
  endtask

  // the primary's transmitter: start, nine bits lsb first, stop
  task automatic link_send(input logic [8:0] f);
    logic [10:0] s;
    s = {1'h1, f, 1'h0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys);
      ir_in <= s[i];
      repeat (BC - 1) @(posedge clk_sys);
    end
  endtask

  // hand one char to the host end, held until taken
  task automatic host_send(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    tx_data  <= d;
    tx_valid <= 1'h1;
    @(posedge clk_sys);
    while (tx_ready !== 1'h1 && n < 4 * FB) begin
      @(posedge clk_sys);
      n++;
    end
    chk("host accept", 9'h001, {8'h00, tx_ready});
    tx_valid <= 1'h0;
  endtask

  function automatic logic [8:0] status_frame(input logic dtr, input logic cd, input logic ri);
    logic [7:0] v;
    v = irda_port_pkg::CTRL_STATUS;
    v[irda_port_pkg::STAT_DSR] = dtr;
    v[irda_port_pkg::STAT_CD] = cd;
    v[irda_port_pkg::STAT_RI] = ri;
    return {1'h1, v};
  endfunction

  // watchdog
  initial begin
    #3_000_000;
    bad_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    chk("reset out low", 9'h000, {8'h00, dev_rst_n});
    rst <= 1'h0;
    repeat (2) @(posedge clk_sys);
    chk("reset out high", 9'h001, {8'h00, dev_rst_n});
    for (int i = 0; i < 7; i++) begin
      b = $random(seed);
      eq.push_back(b);
      host_send(b);
      if (i == 5) begin
        repeat (22 * BC) @(posedge clk_sys);
        chk("cts full", 9'h001, {8'h00, port_if.cts_n});
      end
    end
    repeat (2 * FB) @(posedge clk_sys);
    chk("idle link", 9'h000, 9'(lq.size()));
    chk("dsr unlinked", 9'h001, {8'h00, port_if.dsr_n});
    ml = 3'($random(seed));
    {ready_for_ir, carrier, ring} <= ml;
    link_send({1'h1, irda_port_pkg::CTRL_CONNECT});
    repeat (4) @(posedge clk_sys);
    chk("dsr linked", 9'h000, {8'h00, port_if.dsr_n});
    chk("host link", 9'h001, {8'h00, host_link});
    take(1'h0, status_frame(ml[2], ml[1], ml[0]));
    while (eq.size() > 0) take(1'h0, {1'h0, eq.pop_front()});
    repeat (4) begin
      ml = ml ^ (3'($random(seed)) | 3'h1);
      {ready_for_ir, carrier, ring} <= ml;
      take(1'h0, status_frame(ml[2], ml[1], ml[0]));
    end
    link_send({1'h1, irda_port_pkg::CTRL_STATUS | 8'h07});
    link_send(9'h155);
    chk("dsr remote", 9'h000, {8'h00, port_if.dsr_n});
    for (int i = 0; i < 3; i++) begin
      b = $random(seed);
      eq.push_back(b);
      link_send({1'h0, b});
    end
    repeat (2 * FB) @(posedge clk_sys);
    chk("held chars", 9'h000, 9'(hq.size()));
    rx_allow <= 1'h1;
    while (eq.size() > 0) take(1'h1, {1'h0, eq.pop_front()});
    link_send(9'h000);
    link_send(9'h0ff);
    take(1'h1, 9'h000);
    take(1'h1, 9'h0ff);
    link_send({1'h1, irda_port_pkg::CTRL_DISCONNECT});
    repeat (4) @(posedge clk_sys);
    chk("dsr dropped", 9'h001, {8'h00, port_if.dsr_n});
    link_send(9'h0a5);
    host_send(8'h5a);
    repeat (2 * FB) @(posedge clk_sys);
    chk("after drop", 9'h000, 9'(hq.size() + lq.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
